// File: inc/smp_pkg.sv
package smp_pkg;

	// ----------------------------------------------------------------
	// clock and time base
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int NS_PER_MS     = 1000000;
	// cycles of sys_clk_in in one millisecond
	localparam int MS_CYCLES     = NS_PER_MS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// setting ranges, used to clamp out-of-range settings
	// ----------------------------------------------------------------
	localparam logic [7:0] GAP_MAX_MS = 8'hc8;   // 200 ms
	localparam logic [9:0] TMO_MIN_MS = 10'h00a; // 10 ms
	localparam logic [9:0] TMO_MAX_MS = 10'h3e8; // 1000 ms
	localparam logic [6:0] FAULT_MAX  = 7'h64;   // 100 faults
	localparam logic [6:0] FAULT_SAT  = 7'h7f;

	// ----------------------------------------------------------------
	// anomaly codes
	// ----------------------------------------------------------------
	localparam logic [7:0] ANOM_NONE       = 8'h00;
	localparam logic [7:0] ANOM_SER_MASTER = 8'h07;

	// ----------------------------------------------------------------
	// variable selections; codes 1..5 mean the same for both variables
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		V1_RSVD, V1_WR_PV, V1_RW_SP, V1_WR_OUT, V1_RW_AL1, V1_WR_CONST,
		V1_RD_PV
	} smp_var1_e;

	typedef enum logic [2:0] {
		V2_OFF, V2_WR_PV, V2_RW_SP, V2_WR_OUT, V2_RW_AL1, V2_WR_CONST
	} smp_var2_e;

	typedef enum logic [2:0] {
		S_IDLE, S_PREP, S_ISSUE, S_WAIT, S_GAP
	} smp_state_e;

endpackage

// File: rtl/smp_rescale.sv
`timescale 1ns/1ns
module smp_rescale
	import smp_pkg::*;
(
	input  wire logic signed [15:0] lo_in,
	input  wire logic signed [15:0] hi_in,
	input  wire logic signed [15:0] local_in,
	input  wire logic        [15:0] reg_in,
	output logic             [15:0] to_reg_out,
	output logic signed      [15:0] to_local_out
);

	// ----------------------------------------------------------------
	// saturation
	// ----------------------------------------------------------------
	function automatic logic signed [17:0] smp_clamp(
		input logic signed [17:0] v,
		input logic signed [17:0] lo,
		input logic signed [17:0] hi);
		if (v < lo) begin
			smp_clamp = lo;
		end else if (v > hi) begin
			smp_clamp = hi;
		end else begin
			smp_clamp = v;
		end
	endfunction

	logic signed [17:0] lo18;
	logic signed [17:0] hi18;
	logic signed [17:0] loc18;
	logic signed [17:0] reg18;
	logic               bypass;

	// ----------------------------------------------------------------
	// offset map, saturated at the limits
	// ----------------------------------------------------------------
	// an empty span (defaults 0/0) passes values through unchanged
	always_comb begin
		lo18   = 18'(lo_in);
		hi18   = 18'(hi_in);
		loc18  = 18'(local_in);
		reg18  = signed'({2'b00, reg_in});
		bypass = (hi_in <= lo_in);
		if (bypass) begin
			to_reg_out = local_in;
		end else begin
			to_reg_out = 16'(smp_clamp(loc18, lo18, hi18) - lo18);
		end
		if (bypass) begin
			to_local_out = signed'(reg_in);
		end else begin
			to_local_out = 16'(smp_clamp(lo18 + reg18, lo18, hi18));
		end
	end

endmodule

// File: rtl/smp_poller.sv
// Notes on behaviour
// - second variable: off, write pv, r/w setpoint, write out%, r/w al1, const
// - second variable uses its own 16-bit slave register address
// - first variable has low and high rescaling limits, default zero
// - second variable has low and high rescaling limits, default zero
// - write-constant selection sends the stored 16-bit constant
// - wait at least the gap setting after a reply before next query
// - abandon reception when no reply within the timeout, 10 to 1000 ms
// - each timeout abandon adds one to the lost-packet counter
// - timeouts and crc errors count; reaching the maximum flags offline
// - any good exchange clears the consecutive-fault counter
// - a maximum of zero never flags the slave offline
// - offline switches regulation off and reports serial master anomaly
// - master mode off issues no queries
// - queries carry the configured slave number
// - read-process selection takes the process value from the slave
`timescale 1ns/1ns
module smp_poller
	import smp_pkg::*;
#(
	parameter int MS_CYCLES_P = MS_CYCLES
) (
	input  wire logic               sys_clk_in,
	input  wire logic               rst_b_in,
	input  wire logic               ce_in,
	input  wire logic               master_en_in,
	input  wire logic        [7:0]  slave_addr_in,
	input  wire logic        [2:0]  var_one_select_in,
	input  wire logic        [15:0] var_one_addr_in,
	input  wire logic signed [15:0] var_one_low_limit_in,
	input  wire logic signed [15:0] var_one_high_limit_in,
	input  wire logic        [15:0] var_one_const_in,
	input  wire logic        [2:0]  var_two_select_in,
	input  wire logic        [15:0] var_two_addr_in,
	input  wire logic signed [15:0] var_two_low_limit_in,
	input  wire logic signed [15:0] var_two_high_limit_in,
	input  wire logic        [15:0] var_two_const_in,
	input  wire logic        [7:0]  inter_query_gap_in,
	input  wire logic        [9:0]  reply_timeout_in,
	input  wire logic        [6:0]  max_consecutive_faults_in,
	input  wire logic signed [15:0] pv_in,
	input  wire logic signed [15:0] setpoint_in,
	input  wire logic signed [15:0] out_pct_in,
	input  wire logic signed [15:0] alarm1_sp_in,
	input  wire logic               query_ready_in,
	input  wire logic               reply_ok_in,
	input  wire logic               reply_crc_err_in,
	input  wire logic        [15:0] reply_data_in,
	output logic                    query_valid_out,
	output logic                    query_write_out,
	output logic             [7:0]  query_slave_out,
	output logic             [15:0] query_addr_out,
	output logic             [15:0] query_data_out,
	output logic                    abort_rx_out,
	output logic                    rd_strobe_out,
	output logic                    rd_var_out,
	output logic             [2:0]  rd_sel_out,
	output logic signed      [15:0] rd_data_out,
	output logic             [15:0] lost_packets_out,
	output logic             [6:0]  fault_count_out,
	output logic                    slave_offline_out,
	output logic                    reg_off_out,
	output logic             [7:0]  anomaly_code_out
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	smp_state_e         state_ff;
	smp_state_e         nxt_state;
	logic               var_ff;
	logic [15:0]        pre_ff;
	logic [9:0]         ms_ff;
	logic [15:0]        last_ff [2];
	logic [1:0]         sent_ff;
	logic               abort_ff;
	logic               offline_ff;
	logic [6:0]         fault_ff;
	logic [6:0]         nxt_fault;
	logic               v1_en;
	logic               v2_en;
	logic [2:0]         cur_sel;
	logic signed [15:0] cur_lo;
	logic signed [15:0] cur_hi;
	logic signed [15:0] cur_local;
	logic [15:0]        to_reg;
	logic signed [15:0] to_local;
	logic               is_read;
	logic               tick;
	logic               in_wait;
	logic               tmo;
	logic               good;
	logic               fault;
	logic [7:0]         gap_lim;
	logic [9:0]         tmo_lim;
	logic [6:0]         max_lim;

	// local quantity named by a selection code; values come in as
	// arguments so the continuous assignment follows every one of them
	function automatic logic signed [15:0] smp_local(
		input logic        [2:0]  s,
		input logic signed [15:0] pv,
		input logic signed [15:0] sp,
		input logic signed [15:0] op,
		input logic signed [15:0] al);
		case (s)
			3'h2:    smp_local = sp;
			3'h3:    smp_local = op;
			3'h4:    smp_local = al;
			default: smp_local = pv;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// settings and current variable
	// ----------------------------------------------------------------
	// clamp settings so a wild value cannot stall or spin the poller
	assign gap_lim = (inter_query_gap_in > GAP_MAX_MS) ? GAP_MAX_MS
		: inter_query_gap_in;
	assign tmo_lim = (reply_timeout_in < TMO_MIN_MS) ? TMO_MIN_MS
		: (reply_timeout_in > TMO_MAX_MS) ? TMO_MAX_MS : reply_timeout_in;
	assign max_lim = (max_consecutive_faults_in > FAULT_MAX) ? FAULT_MAX
		: max_consecutive_faults_in;
	assign v1_en = (smp_var1_e'(var_one_select_in) != V1_RSVD)
		&& (var_one_select_in <= 3'(V1_RD_PV));
	assign v2_en = (smp_var2_e'(var_two_select_in) != V2_OFF)
		&& (var_two_select_in <= 3'(V2_WR_CONST));
	assign cur_sel   = var_ff ? var_two_select_in : var_one_select_in;
	// limits follow the variable in flight
	assign cur_lo    = var_ff ? var_two_low_limit_in : var_one_low_limit_in;
	assign cur_hi    = var_ff ? var_two_high_limit_in : var_one_high_limit_in;
	assign cur_local = smp_local(cur_sel, pv_in, setpoint_in, out_pct_in,
		alarm1_sp_in);
	// read/write items write on the first pass, then only when the scaled value moved
	assign is_read = (cur_sel == 3'(V1_RD_PV))
		|| (((cur_sel == 3'(V1_RW_SP)) || (cur_sel == 3'(V1_RW_AL1)))
		&& sent_ff[var_ff] && (last_ff[var_ff] == to_reg));

	smp_rescale u_rescale (
		.lo_in        (cur_lo),
		.hi_in        (cur_hi),
		.local_in     (cur_local),
		.reg_in       (reply_data_in),
		.to_reg_out   (to_reg),
		.to_local_out (to_local)
	);

	// ----------------------------------------------------------------
	// events of the wait state
	// ----------------------------------------------------------------
	assign in_wait = (state_ff == S_WAIT);
	assign good    = in_wait && reply_ok_in && !reply_crc_err_in;
	assign tmo     = in_wait && !reply_ok_in && !reply_crc_err_in
		&& (ms_ff >= tmo_lim);
	assign fault   = tmo || (in_wait && reply_crc_err_in);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: begin
				if (master_en_in && (v1_en || v2_en)) begin
					nxt_state = S_PREP;
				end
			end
			S_PREP:  nxt_state = S_ISSUE;
			S_ISSUE: begin
				if (query_ready_in) begin
					nxt_state = S_WAIT;
				end
			end
			S_WAIT: begin
				if (reply_ok_in || reply_crc_err_in || tmo) begin
					nxt_state = S_GAP;
				end
			end
			S_GAP: begin
				if (ms_ff >= 10'(gap_lim)) begin
					nxt_state = S_IDLE;
				end
			end
			default: nxt_state = S_IDLE;
		endcase
		// master off drops back to idle
		if (!master_en_in) begin
			nxt_state = S_IDLE;
		end
	end

	// state and variable choice
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_ff <= S_IDLE;
			var_ff   <= 1'b0;
		end else if (ce_in) begin
			state_ff <= nxt_state;
			// the other variable when both on, so a variable enabled
			// late never waits behind a second turn of its partner
			if (state_ff == S_IDLE && nxt_state == S_PREP) begin
				var_ff <= (v1_en && v2_en) ? !var_ff : (v2_en && !v1_en);
			end
		end
	end

	// millisecond base, restarted on every state change for exact waits
	assign tick = (pre_ff == 16'(MS_CYCLES_P - 1));

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pre_ff <= 16'h0000;
			ms_ff  <= 10'h000;
		end else if (ce_in) begin
			if (nxt_state != state_ff) begin
				pre_ff <= 16'h0000;
				ms_ff  <= 10'h000;
			end else if (tick) begin
				pre_ff <= 16'h0000;
				if (ms_ff != 10'h3ff) begin
					ms_ff <= ms_ff + 10'h001;
				end
			end else begin
				pre_ff <= pre_ff + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// query fields, captured once so they stay still during the offer
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			query_write_out <= 1'b0;
			query_slave_out <= 8'h00;
			query_addr_out  <= 16'h0000;
			query_data_out  <= 16'h0000;
		end else if (ce_in && state_ff == S_PREP) begin
			query_write_out <= !is_read;
			query_slave_out <= slave_addr_in;
			query_addr_out  <= var_ff ? var_two_addr_in : var_one_addr_in;
			if (cur_sel == 3'(V1_WR_CONST)) begin
				query_data_out <= var_ff ? var_two_const_in : var_one_const_in;
			end else begin
				query_data_out <= to_reg;
			end
		end
	end

	// last written value of each read/write item
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			last_ff[0] <= 16'h0000;
			last_ff[1] <= 16'h0000;
			sent_ff    <= 2'b00;
		end else if (ce_in && state_ff == S_PREP && !is_read) begin
			last_ff[var_ff] <= to_reg;
			sent_ff[var_ff] <= 1'b1;
		end
	end

	// offer only from issue, never while a reply is awaited
	assign query_valid_out = (state_ff == S_ISSUE) && master_en_in;

	// ----------------------------------------------------------------
	// replies: read results and abandon pulse
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_strobe_out <= 1'b0;
			rd_var_out    <= 1'b0;
			rd_sel_out    <= 3'h0;
			rd_data_out   <= 16'h0000;
			abort_ff      <= 1'b0;
		end else if (ce_in) begin
			// read result, remote pv when sel is read-process
			rd_strobe_out <= good && !query_write_out;
			abort_ff      <= tmo || (in_wait && !master_en_in);
			if (good && !query_write_out) begin
				rd_var_out  <= var_ff;
				rd_sel_out  <= cur_sel;
				rd_data_out <= to_local;
			end
		end
	end

	assign abort_rx_out = abort_ff;

	// ----------------------------------------------------------------
	// fault accounting
	// ----------------------------------------------------------------
	always_comb begin
		nxt_fault = fault_ff;
		// a fault in the same cycle wins over a clear
		if (fault) begin
			nxt_fault = (fault_ff == FAULT_SAT) ? fault_ff : fault_ff + 7'h01;
		end else if (good) begin
			nxt_fault = 7'h00;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fault_ff         <= 7'h00;
			offline_ff       <= 1'b0;
			lost_packets_out <= 16'h0000;
			anomaly_code_out <= ANOM_NONE;
		end else if (ce_in) begin
			fault_ff <= nxt_fault;
			// offline at the maximum, never when it is zero
			offline_ff <= (max_lim != 7'h00) && (nxt_fault >= max_lim);
			if (tmo) begin
				lost_packets_out <= lost_packets_out + 16'h0001;
			end
			// anomaly code follows the offline flag
			anomaly_code_out <= ((max_lim != 7'h00) && (nxt_fault >= max_lim))
				? ANOM_SER_MASTER : ANOM_NONE;
		end
	end

	assign fault_count_out   = fault_ff;
	assign slave_offline_out = offline_ff;
	// regulation output off while the slave is offline
	assign reg_off_out       = offline_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_accept;
		query_valid_out && query_ready_in && ce_in;
	endsequence

	property p_no_query_off;
		!master_en_in |-> !query_valid_out;
	endproperty
	a_no_query_off: assert property (p_no_query_off)
		else $error("query offered with master mode off");

	property p_one_outstanding;
		s_accept |=> !query_valid_out [*2];
	endproperty
	a_one_outstanding: assert property (p_one_outstanding)
		else $error("second query while one outstanding");

	property p_alternate;
		(ce_in && state_ff == S_IDLE && nxt_state == S_PREP
			&& v1_en && v2_en) |=> var_ff != $past(var_ff);
	endproperty
	a_alternate: assert property (p_alternate)
		else $error("variables did not alternate");

	property p_lost;
		(tmo && ce_in) |=> lost_packets_out == $past(lost_packets_out) + 16'h1;
	endproperty
	a_lost: assert property (p_lost)
		else $error("lost counter missed a timeout");

	property p_clear;
		(good && !fault && ce_in) |=> fault_ff == 7'h00;
	endproperty
	a_clear: assert property (p_clear)
		else $error("good reply did not clear faults");

	property p_zero_max;
		(max_lim == 7'h00 && ce_in) |=> !slave_offline_out;
	endproperty
	a_zero_max: assert property (p_zero_max)
		else $error("offline raised with maximum zero");

	property p_offline;
		(ce_in && max_lim != 7'h00 && nxt_fault >= max_lim) |=>
			slave_offline_out && reg_off_out
			&& anomaly_code_out == ANOM_SER_MASTER;
	endproperty
	a_offline: assert property (p_offline)
		else $error("offline not flagged at maximum");

	property p_gap;
		(good && ce_in && gap_lim != 8'h00) |=> !query_valid_out [*8];
	endproperty
	a_gap: assert property (p_gap)
		else $error("query too soon after reply");

	property p_timeout;
		tmo |-> in_wait && ms_ff >= TMO_MIN_MS && ms_ff <= TMO_MAX_MS;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("timeout outside allowed window");

	property p_fields;
		s_accept |-> query_slave_out == slave_addr_in && query_addr_out ==
			(var_ff ? var_two_addr_in : var_one_addr_in);
	endproperty
	a_fields: assert property (p_fields)
		else $error("query slave or address wrong");

endmodule

// File: dv/smp_slave_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// remote slave seen through the frame engine
// ----------------------------------------------------------------
module smp_slave_model (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        valid_in,
	input  wire logic [1:0]  mode_in,
	input  wire logic [3:0]  lat_in,
	input  wire logic [15:0] resp_in,
	output logic             ready_out,
	output logic             ok_out,
	output logic             crc_out,
	output logic [15:0]      data_out
);
	// mode 0 good reply, 1 crc error, 2 silent
	initial begin
		ready_out = 1'b0;
		ok_out    = 1'b0;
		crc_out   = 1'b0;
		data_out  = 16'h5a5a;
	end

	// take one query, raise ready for it after lat_in cycles
	// reply lat_in cycles after ready; no reply at all in silent mode 2
	always begin
		@(posedge clk_in);
		if (rst_b_in === 1'b1 && valid_in === 1'b1) begin
			repeat (lat_in) @(posedge clk_in);
			ready_out <= 1'b1;
			@(posedge clk_in);
			ready_out <= 1'b0;
			if (mode_in != 2'h2) begin
				repeat (lat_in) @(posedge clk_in);
				ok_out   <= (mode_in == 2'h0);
				crc_out  <= (mode_in == 2'h1);
				data_out <= resp_in;
				@(posedge clk_in);
				ok_out   <= 1'b0;
				crc_out  <= 1'b0;
				// data not held past the strobe, so stale reads show
				data_out <= ~resp_in;
			end
		end
	end
endmodule

// File: dv/smp_poller_tb.sv
`timescale 1ns/1ns
module smp_poller_tb;
	import smp_pkg::*;
	localparam int MSC = 4;
	logic               sys_clk_in, rst_b_in, men, rdy, ok, crc;
	logic        [2:0]  sel1, sel2, rdsel;
	logic        [15:0] a1, a2, k1, k2, resp, rdat, qa, qd, lost;
	logic signed [15:0] lo1, hi1, lo2, hi2, pv, rdd, rd_last;
	logic        [7:0]  sa, gap, qs, anom;
	logic        [9:0]  tmo;
	logic        [6:0]  maxf, fc;
	logic        [1:0]  mode;
	logic        [3:0]  lat;
	logic               qv, qw, abort, rds, rdv, offl, roff, ce;
	int                 failures, checked, cyc, n_take, n_rep, n_abort;
	int                 n_valid, t_take, t_rep, t_abort, d;
	logic        [15:0] qa_q[$], qd_q[$];
	logic               qw_q[$];

	smp_poller #(.MS_CYCLES_P(MSC)) i_dut (
		.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .ce_in(ce),
		.master_en_in(men), .slave_addr_in(sa),
		.var_one_select_in(sel1), .var_one_addr_in(a1),
		.var_one_low_limit_in(lo1), .var_one_high_limit_in(hi1),
		.var_one_const_in(k1), .var_two_select_in(sel2),
		.var_two_addr_in(a2), .var_two_low_limit_in(lo2),
		.var_two_high_limit_in(hi2), .var_two_const_in(k2),
		.inter_query_gap_in(gap), .reply_timeout_in(tmo),
		.max_consecutive_faults_in(maxf), .pv_in(pv),
		.setpoint_in(16'sh0011), .out_pct_in(16'sh0022),
		.alarm1_sp_in(16'sh0033), .query_ready_in(rdy),
		.reply_ok_in(ok), .reply_crc_err_in(crc), .reply_data_in(rdat),
		.query_valid_out(qv), .query_write_out(qw),
		.query_slave_out(qs), .query_addr_out(qa), .query_data_out(qd),
		.abort_rx_out(abort), .rd_strobe_out(rds), .rd_var_out(rdv),
		.rd_sel_out(rdsel), .rd_data_out(rdd), .lost_packets_out(lost),
		.fault_count_out(fc), .slave_offline_out(offl),
		.reg_off_out(roff), .anomaly_code_out(anom)
	);

	smp_slave_model i_slave (
		.clk_in(sys_clk_in), .rst_b_in(rst_b_in), .valid_in(qv),
		.mode_in(mode), .lat_in(lat), .resp_in(resp),
		.ready_out(rdy), .ok_out(ok), .crc_out(crc), .data_out(rdat)
	);

	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] e,
			input logic [15:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d, failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// bounded waits on reply and abort counts
	task automatic wait_rep(input int tgt);
		for (int i = 0; i < 3000 && n_rep < tgt; i++) @(posedge sys_clk_in);
		chk("reply count", 16'(n_rep >= tgt), 16'h1);
		repeat (3) @(posedge sys_clk_in);
	endtask

	task automatic wait_abt(input int tgt);
		for (int i = 0; i < 3000 && n_abort < tgt; i++) @(posedge sys_clk_in);
		chk("abort count", 16'(n_abort >= tgt), 16'h1);
		repeat (3) @(posedge sys_clk_in);
	endtask

	// master off, let the slave model drain
	task automatic stop;
		@(posedge sys_clk_in);
		men <= 1'b0;
		repeat (40) @(posedge sys_clk_in);
	endtask

	// ----------------------------------------------------------------
	// clock, reset and monitor
	// ----------------------------------------------------------------
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end

	// watches every take and reply; gap and slave number checked here
	always @(posedge sys_clk_in) begin
		cyc++;
		if (qv === 1'b1) n_valid++;
		if (qv === 1'b1 && rdy === 1'b1) begin
			n_take++;
			t_take = cyc;
			qa_q.push_back(qa);
			qd_q.push_back(qd);
			qw_q.push_back(qw);
			chk("slave number", {8'h00, sa}, {8'h00, qs});
			chk("gap", 16'((cyc - t_rep) >= int'(gap) * MSC), 16'h1);
		end
		if (ok === 1'b1 || crc === 1'b1) begin
			n_rep++;
			t_rep = cyc;
		end
		if (abort === 1'b1) begin
			n_abort++;
			t_abort = cyc;
		end
		if (rds === 1'b1) rd_last = rdd;
		if (cyc > 30000) begin
			failures++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_master_off;
		int nv;
		nv = n_valid;
		@(posedge sys_clk_in);
		sel1 <= 3'h5;
		repeat (100) @(posedge sys_clk_in);
		chk("valid while off", 16'(n_valid - nv), 16'h0);
		// clock enable low freezes idle even with master mode on
		ce  <= 1'b0;
		men <= 1'b1;
		repeat (50) @(posedge sys_clk_in);
		chk("valid while frozen", 16'(n_valid - nv), 16'h0);
		men <= 1'b0;
		ce  <= 1'b1;
		@(posedge sys_clk_in);
	endtask

	task automatic t_alternate;
		qa_q.delete();
		qd_q.delete();
		qw_q.delete();
		@(posedge sys_clk_in);
		sel2 <= 3'h1;
		lo2  <= -16'sd100;
		hi2  <= 16'sd1000;
		pv   <= 16'sd1500;
		men  <= 1'b1;
		wait_rep(n_rep + 4);
		stop();
		for (int i = 0; i < 4; i++) begin
			if (i > 0)
				chk("alternate", 16'(qa_q[i] != qa_q[i-1]), 16'h1);
			chk("write flag", 16'h1, {15'h0, qw_q[i]});
			if (qa_q[i] === a1) chk("const data", k1, qd_q[i]);
			else chk("var2 addr", a2, qa_q[i]);
			if (qa_q[i] === a2)
				chk("var2 scaled", 16'h044c, qd_q[i]);
		end
	endtask

	// read/write items: first pass writes, an unchanged second pass reads
	task automatic t_rw;
		qa_q.delete();
		qd_q.delete();
		qw_q.delete();
		@(posedge sys_clk_in);
		sel1 <= 3'h4;
		sel2 <= 3'h2;
		lo1  <= 16'sd0;
		hi1  <= 16'sd0;
		men  <= 1'b1;
		wait_rep(n_rep + 4);
		stop();
		sel2 <= 3'h0;
		for (int i = 0; i < 4; i++) begin
			chk("rw write flag", 16'(i < 2), {15'h0, qw_q[i]});
			if (qa_q[i] === a1) chk("alarm data", 16'h0033, qd_q[i]);
			else chk("setpoint data", 16'h0075, qd_q[i]);
		end
	endtask

	task automatic t_read;
		@(posedge sys_clk_in);
		sel1 <= 3'h6;
		sel2 <= 3'h0;
		lo1  <= 16'sd100;
		hi1  <= 16'sd1000;
		resp <= 16'h00c8;
		lat  <= 4'h5;
		men  <= 1'b1;
		wait_rep(n_rep + 1);
		chk("read data", 16'h012c, rd_last);
		chk("read var", 16'h0, {15'h0, rdv});
		chk("read sel", 16'h6, {13'h0, rdsel});
		chk("read flag", 16'h0, {15'h0, qw});
		resp <= 16'h07d0;
		wait_rep(n_rep + 1);
		chk("read saturated", 16'h03e8, rd_last);
		stop();
	endtask

	task automatic t_timeout;
		logic [15:0] l0;
		logic [6:0]  f0;
		l0 = lost;
		f0 = fc;
		@(posedge sys_clk_in);
		sel1 <= 3'h5;
		mode <= 2'h2;
		lat  <= 4'h1;
		men  <= 1'b1;
		wait_abt(n_abort + 1);
		d = t_abort - t_take;
		chk("timeout window", 16'(d >= 40 && d <= 44), 16'h1);
		chk("lost packets", l0 + 16'h1, lost);
		chk("fault count", {9'h0, f0} + 16'h1, {9'h0, fc});
		stop();
	endtask

	// four consecutive crc faults whatever the limit, then one good exchange
	task automatic t_faults(input logic [6:0] lim);
		logic [6:0] e;
		logic       off;
		e = fc;
		@(posedge sys_clk_in);
		maxf <= lim;
		mode <= 2'h1;
		men  <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			wait_rep(n_rep + 1);
			e = e + 7'h1;
			off = (lim != 7'h00) && (e >= lim);
			chk("fault count", {9'h0, e}, {9'h0, fc});
			chk("offline", {15'h0, off}, {15'h0, offl});
			chk("reg off", {15'h0, off}, {15'h0, roff});
			chk("anomaly", off ? 16'h0007 : 16'h0, {8'h0, anom});
		end
		mode <= 2'h0;
		wait_rep(n_rep + 1);
		chk("fault cleared", 16'h0, {9'h0, fc});
		chk("online again", 16'h0, {15'h0, offl});
		chk("regulation on", 16'h0, {15'h0, roff});
		chk("anomaly cleared", 16'h0, {8'h0, anom});
		stop();
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_b_in = 1'b0;
		ce = 1'b1;
		men = 1'b0;
		sel1 = 3'h0;
		sel2 = 3'h0;
		a1 = 16'd1000;
		a2 = 16'd1001;
		k1 = 16'hbeef;
		k2 = 16'h1234;
		lo1 = 16'sd0;
		hi1 = 16'sd0;
		lo2 = 16'sd0;
		hi2 = 16'sd0;
		pv = 16'sd0;
		sa = 8'h2a;
		gap = 8'h02;
		tmo = 10'h00a;
		maxf = 7'h03;
		mode = 2'h0;
		lat = 4'h1;
		resp = 16'h0000;
		t_rep = -100000;
		repeat (3) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		chk("lost at reset", 16'h0, lost);
		chk("offline at reset", 16'h0, {15'h0, offl});
		t_master_off();
		t_alternate();
		t_read();
		t_rw();
		t_timeout();
		t_faults(7'h03);
		t_faults(7'h00);
		end_of_test();
	end
endmodule
